// ===== logic/qbp_bit_merge.sv
`timescale 1ns/100ps
module qbp_bit_merge
  import qbp_pkg::*;
(
  input  wire logic [7:0] byte_i,
  input  wire logic [2:0] sel_i,
  input  qbp_op_t         op_i,
  input  wire logic       carry_i,
  output logic      [7:0] byte_o,
  output logic            old_bit_o
);

  logic new_bit;

  always_comb begin
    old_bit_o = byte_i[sel_i];
    case (op_i)
      QBP_OP_MOVBIT: new_bit = carry_i;
      QBP_OP_SETBIT: new_bit = 1'b1;
      QBP_OP_CPL:    new_bit = ~byte_i[sel_i];
      default:       new_bit = 1'b0; // clear bit, jump-and-clear
    endcase
    byte_o = byte_i; // whole byte rides along
    byte_o[sel_i] = new_bit; // only the addressed bit moves
  end

endmodule : qbp_bit_merge

// ===== logic/qbp_defs.svh
`ifndef QBP_DEFS_SVH
`define QBP_DEFS_SVH

// port latch register offsets on the internal special-function bus
`define QBP_OFF_PORT_ONE   8'h90
`define QBP_OFF_PORT_TWO   8'ha0
`define QBP_OFF_PORT_THREE 8'hb0
`define QBP_OFF_PORT_FOUR  8'hc0

// latch reset value and unmapped read value
`define QBP_LATCH_RST      8'hff
`define QBP_UNMAPPED_RD    8'hff

// strong pull-up kick, in oscillator periods, and as clock cycles
`define QBP_KICK_PERIODS   2
`define QBP_OSC_PER_CLOCK  1
`define QBP_KICK_CYCLES    (`QBP_KICK_PERIODS * `QBP_OSC_PER_CLOCK)

`endif

// ===== logic/qbp_pin_cell.sv
`timescale 1ns/100ps
module qbp_pin_cell
  import qbp_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic buf_i,
  input  wire logic pin_i,
  input  wire logic kick_en_i,
  output logic      pulldown_o,
  output logic      kick_o,
  output logic      keeper_o,
  output logic      very_weak_o
);

  `include "qbp_defs.svh"

  localparam logic [1:0] KICK_LOAD = 2'(`QBP_KICK_CYCLES);

  logic       buf_prev_reg;
  logic       buf_prev_next;
  logic [1:0] kick_cnt_reg;
  logic [1:0] kick_cnt_next;
  logic       pulldown_reg;
  logic       pulldown_next;
  logic       kick_reg;
  logic       kick_next;
  logic       keeper_reg;
  logic       keeper_next;
  logic       very_weak_reg;
  logic       very_weak_next;

  always_comb begin
    buf_prev_next = buf_i;
    if (buf_i && !buf_prev_reg && kick_en_i) begin
      kick_cnt_next = KICK_LOAD; // zero-to-one edge of the buffer
    end else if (kick_cnt_reg != 2'h0) begin
      kick_cnt_next = kick_cnt_reg - 2'h1;
    end else begin
      kick_cnt_next = 2'h0;
    end
    pulldown_next  = ~buf_i; // latch zero drives low
    kick_next      = buf_i && (kick_cnt_next != 2'h0);
    keeper_next    = buf_i && pin_i; // keeper follows the pin
    very_weak_next = buf_i; // on exactly while pull-down is off
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      // reset leaves only the pin held high, never a kick
      buf_prev_reg  <= 1'b1;
      kick_cnt_reg  <= 2'h0;
      pulldown_reg  <= 1'b0;
      kick_reg      <= 1'b0;
      keeper_reg    <= 1'b1;
      very_weak_reg <= 1'b1;
    end else begin
      buf_prev_reg  <= buf_prev_next;
      kick_cnt_reg  <= kick_cnt_next;
      pulldown_reg  <= pulldown_next;
      kick_reg      <= kick_next;
      keeper_reg    <= keeper_next;
      very_weak_reg <= very_weak_next;
    end
  end

  assign pulldown_o  = pulldown_reg;
  assign kick_o      = kick_reg;
  assign keeper_o    = keeper_reg;
  assign very_weak_o = very_weak_reg;

  property p_kick_two;
    @(posedge clock_i) disable iff (!rst_n_i)
    (kick_en_i && $rose(buf_i)) ##1 buf_i |=> kick_reg ##1 !kick_reg;
  endproperty
  a_kick_two: assert property (p_kick_two)
    else $error("strong kick not two cycles");

  property p_keeper;
    @(posedge clock_i) disable iff (!rst_n_i)
    (buf_i && pin_i) |=> keeper_reg;
  endproperty
  a_keeper: assert property (p_keeper)
    else $error("keeper off while pin high");

  property p_very_weak;
    @(posedge clock_i) disable iff (!rst_n_i)
    pulldown_reg |-> !very_weak_reg && !keeper_reg;
  endproperty
  a_very_weak: assert property (p_very_weak)
    else $error("pull-up on with pull-down");

  property p_no_kick_reset;
    @(posedge clock_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> !kick_reg && keeper_reg && !pulldown_reg;
  endproperty
  a_no_kick_reset: assert property (p_no_kick_reset)
    else $error("kick active out of reset");

  property p_low_drive;
    @(posedge clock_i) disable iff (!rst_n_i)
    !buf_i |=> pulldown_reg && !kick_reg && !keeper_reg && !very_weak_reg;
  endproperty
  a_low_drive: assert property (p_low_drive)
    else $error("latch zero not driving low");

  property p_release;
    @(posedge clock_i) disable iff (!rst_n_i)
    !buf_i ##1 buf_i |=> !pulldown_reg && very_weak_reg;
  endproperty
  a_release: assert property (p_release)
    else $error("pin not released to input");

  c_kick: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(kick_reg));

endmodule : qbp_pin_cell

// ===== logic/qbp_pkg.sv
package qbp_pkg;

  // operation class presented by the core with each port access
  typedef enum logic [3:0] {
    QBP_OP_PLAIN   = 4'h0,
    QBP_OP_AND     = 4'h1,
    QBP_OP_OR      = 4'h2,
    QBP_OP_XOR     = 4'h3,
    QBP_OP_JBC     = 4'h4,
    QBP_OP_CPL     = 4'h5,
    QBP_OP_INC     = 4'h6,
    QBP_OP_DEC     = 4'h7,
    QBP_OP_DECREMENT_JUMP_NONZERO_OP    = 4'h8,
    QBP_OP_MOVBIT  = 4'h9,
    QBP_OP_CLRBIT  = 4'ha,
    QBP_OP_SETBIT  = 4'hb
  } qbp_op_t;

  typedef enum logic [2:0] {
    QBP_ST_IDLE  = 3'b001,
    QBP_ST_READ  = 3'b010,
    QBP_ST_WRITE = 3'b100
  } qbp_state_t;

  function automatic logic qbp_is_rmw(input qbp_op_t op);
    qbp_is_rmw = (op != QBP_OP_PLAIN);
  endfunction : qbp_is_rmw

endpackage : qbp_pkg

// ===== logic/qbp_port_latch.sv
// Notes on behaviour
// - read-modify-write accesses to a port read the latch, not the pins.
// - and, or, xor, jbc, cpl, inc, dec, decrement_jump_nonzero_op and bit moves count as such.
// - bit writes read all eight bits, change one, write the byte back.
// - any other port read returns the sensed pin levels.
// - ports one, two, three, four are quasi-bidirectional with internal pull-ups.
// - every reset sets all latch bits to one.
// - writing one after zero releases the pull-down and pulls the pin high.
// - latch changes at cycle end; the output buffer one cycle later.
// - each zero-to-one latch edge on ports one, three, four enables the strong pull-up for 2 periods.
// - weak keeper pull-up is on while the pin senses one.
// - very weak pull-up is on exactly while the pull-down is off.
// - no strong kick during reset; the keeper and the very weak pull-up hold the pin.
`timescale 1ns/100ps
module qbp_port_latch
  import qbp_pkg::*;
#(
  parameter int         PORTS          = 4,
  parameter int         WIDTH          = 8,
  parameter logic [3:0] KICK_PORT_MASK = 4'b1101
)(
  input  wire logic                         clock_i,
  input  wire logic                         rst_n_i,
  input  wire logic [7:0]                   sfr_addr_i,
  input  wire logic                         sfr_rd_i,
  input  wire logic                         sfr_wr_i,
  input  wire logic [7:0]                   sfr_wdata_i,
  input  qbp_op_t                           sfr_op_i,
  input  wire logic                         sfr_bit_i,
  input  wire logic [2:0]                   sfr_bit_sel_i,
  input  wire logic                         sfr_carry_i,
  input  wire logic [PORTS-1:0][WIDTH-1:0]  pin_i,
  output logic      [7:0]                   rd_data_o,
  output logic                              rd_valid_o,
  output logic                              bit_done_o,
  output logic                              bit_old_o,
  output logic      [PORTS-1:0][WIDTH-1:0]  pulldown_o,
  output logic      [PORTS-1:0][WIDTH-1:0]  strong_kick_pullup_o,
  output logic      [PORTS-1:0][WIDTH-1:0]  weak_keeper_pullup_o,
  output logic      [PORTS-1:0][WIDTH-1:0]  very_weak_pullup_o
);

  `include "qbp_defs.svh"

  if (PORTS != 4 || WIDTH != 8) begin : g_check
    $error("qbp_port_latch serves four 8-bit ports only");
  end

  typedef logic [PORTS-1:0][WIDTH-1:0] qbp_ports_t;

  qbp_ports_t latch_reg;
  qbp_ports_t latch_next;
  qbp_ports_t buf_reg;
  qbp_ports_t buf_next;
  qbp_state_t state_reg;
  qbp_state_t state_next;
  logic [1:0] bit_idx_reg;
  logic [1:0] bit_idx_next;
  logic [2:0] bit_sel_reg;
  logic [2:0] bit_sel_next;
  qbp_op_t    bit_op_reg;
  qbp_op_t    bit_op_next;
  logic       carry_reg;
  logic       carry_next;
  logic [7:0] merge_reg;
  logic [7:0] merge_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic       rd_valid_reg;
  logic       rd_valid_next;
  logic       bit_done_reg;
  logic       bit_done_next;
  logic       bit_old_reg;
  logic       bit_old_next;

  logic       hit;
  logic [1:0] idx;
  logic [7:0] merged;
  logic       merged_old;

  // address decode
  always_comb begin
    hit = 1'b1;
    idx = 2'd0;
    if (sfr_addr_i == `QBP_OFF_PORT_ONE) begin
      idx = 2'd0;
    end else if (sfr_addr_i == `QBP_OFF_PORT_TWO) begin
      idx = 2'd1;
    end else if (sfr_addr_i == `QBP_OFF_PORT_THREE) begin
      idx = 2'd2;
    end else if (sfr_addr_i == `QBP_OFF_PORT_FOUR) begin
      idx = 2'd3;
    end else begin
      hit = 1'b0;
    end
  end

  qbp_bit_merge u_merge (
    .byte_i    (latch_reg[bit_idx_reg]), // latch, not pins
    .sel_i     (bit_sel_reg),
    .op_i      (bit_op_reg),
    .carry_i   (carry_reg),
    .byte_o    (merged),
    .old_bit_o (merged_old)
  );

  // read path
  always_comb begin
    rd_valid_next = sfr_rd_i;
    rd_data_next  = `QBP_UNMAPPED_RD;
    if (sfr_rd_i && hit) begin
      if (qbp_is_rmw(sfr_op_i)) begin
        rd_data_next = latch_reg[idx];
      end else begin
        // a loaded pin may read low with the latch at one
        rd_data_next = pin_i[idx];
      end
    end
  end

  // latch, buffer and bit sequencer
  always_comb begin
    latch_next    = latch_reg;
    buf_next      = latch_reg; // output buffer follows the latch one cycle late
    state_next    = state_reg;
    bit_idx_next  = bit_idx_reg;
    bit_sel_next  = bit_sel_reg;
    bit_op_next   = bit_op_reg;
    carry_next    = carry_reg;
    merge_next    = merge_reg;
    bit_done_next = 1'b0;
    bit_old_next  = bit_old_reg;
    case (state_reg)
      QBP_ST_IDLE: begin
        if (sfr_bit_i && hit) begin
          bit_idx_next = idx;
          bit_sel_next = sfr_bit_sel_i;
          bit_op_next  = sfr_op_i;
          carry_next   = sfr_carry_i;
          state_next   = QBP_ST_READ;
        end else if (sfr_wr_i && hit) begin
          latch_next[idx] = sfr_wdata_i; // end of write cycle
        end
      end
      QBP_ST_READ: begin
        merge_next   = merged;
        bit_old_next = merged_old;
        state_next   = QBP_ST_WRITE;
      end
      QBP_ST_WRITE: begin
        latch_next[bit_idx_reg] = merge_reg; // full byte back
        bit_done_next           = 1'b1;
        state_next              = QBP_ST_IDLE;
      end
      default: begin
        state_next = QBP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      latch_reg    <= {PORTS{`QBP_LATCH_RST}};
      buf_reg      <= {PORTS{`QBP_LATCH_RST}};
      state_reg    <= QBP_ST_IDLE;
      bit_idx_reg  <= 2'd0;
      bit_sel_reg  <= 3'h0;
      bit_op_reg   <= QBP_OP_PLAIN;
      carry_reg    <= 1'b0;
      merge_reg    <= 8'h00;
      rd_data_reg  <= 8'h00;
      rd_valid_reg <= 1'b0;
      bit_done_reg <= 1'b0;
      bit_old_reg  <= 1'b0;
    end else begin
      latch_reg    <= latch_next;
      buf_reg      <= buf_next;
      state_reg    <= state_next;
      bit_idx_reg  <= bit_idx_next;
      bit_sel_reg  <= bit_sel_next;
      bit_op_reg   <= bit_op_next;
      carry_reg    <= carry_next;
      merge_reg    <= merge_next;
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      bit_done_reg <= bit_done_next;
      bit_old_reg  <= bit_old_next;
    end
  end

  assign rd_data_o  = rd_data_reg;
  assign rd_valid_o = rd_valid_reg;
  assign bit_done_o = bit_done_reg;
  assign bit_old_o  = bit_old_reg;

  // one drive cell per pin; port two has no kick device
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      qbp_pin_cell u_cell (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .buf_i       (buf_reg[p][b]),
        .pin_i       (pin_i[p][b]),
        .kick_en_i   (KICK_PORT_MASK[p]),
        .pulldown_o  (pulldown_o[p][b]),
        .kick_o      (strong_kick_pullup_o[p][b]),
        .keeper_o    (weak_keeper_pullup_o[p][b]),
        .very_weak_o (very_weak_pullup_o[p][b])
      );
    end
  end

  property p_rmw_latch;
    @(posedge clock_i) disable iff (!rst_n_i)
    (sfr_rd_i && hit && sfr_op_i != QBP_OP_PLAIN)
      |=> rd_valid_reg && rd_data_reg == $past(latch_reg[idx]);
  endproperty
  a_rmw_latch: assert property (p_rmw_latch)
    else $error("rmw read did not return latch");

  property p_rmw_decrement_jump_nonzero_op;
    @(posedge clock_i) disable iff (!rst_n_i)
    (sfr_rd_i && hit && sfr_op_i == QBP_OP_DECREMENT_JUMP_NONZERO_OP)
      |=> rd_data_reg == $past(latch_reg[idx]);
  endproperty
  a_rmw_decrement_jump_nonzero_op: assert property (p_rmw_decrement_jump_nonzero_op)
    else $error("decrement_jump_nonzero_op read not from latch");

  property p_plain_pin;
    @(posedge clock_i) disable iff (!rst_n_i)
    (sfr_rd_i && hit && sfr_op_i == QBP_OP_PLAIN)
      |=> rd_data_reg == $past(pin_i[idx]);
  endproperty
  a_plain_pin: assert property (p_plain_pin)
    else $error("plain read did not return pins");

  property p_bit_write;
    @(posedge clock_i) disable iff (!rst_n_i)
    (state_reg == QBP_ST_IDLE && sfr_bit_i && hit
      && sfr_op_i == QBP_OP_SETBIT)
      ##2 (state_reg == QBP_ST_WRITE)
      |=> latch_reg[bit_idx_reg][bit_sel_reg] && bit_done_reg;
  endproperty
  a_bit_write: assert property (p_bit_write)
    else $error("set bit did not land in latch");

  property p_reset_ones;
    @(posedge clock_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> latch_reg == {PORTS{`QBP_LATCH_RST}};
  endproperty
  a_reset_ones: assert property (p_reset_ones)
    else $error("latch not all ones after reset");

  property p_buf_lag;
    @(posedge clock_i) disable iff (!rst_n_i)
    $changed(latch_reg) |=> buf_reg == $past(latch_reg);
  endproperty
  a_buf_lag: assert property (p_buf_lag)
    else $error("output buffer did not follow latch");

  property p_wr_lands;
    @(posedge clock_i) disable iff (!rst_n_i)
    (sfr_wr_i && hit && !sfr_bit_i && state_reg == QBP_ST_IDLE)
      |=> latch_reg[$past(idx)] == $past(sfr_wdata_i);
  endproperty
  a_wr_lands: assert property (p_wr_lands)
    else $error("byte write did not reach latch");

  property p_busy_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
    state_reg == QBP_ST_READ |=> $stable(latch_reg);
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("latch moved inside a bit operation");

  property p_one_bit;
    @(posedge clock_i) disable iff (!rst_n_i)
    state_reg == QBP_ST_WRITE
      |=> $onehot0(latch_reg[bit_idx_reg] ^ $past(latch_reg[bit_idx_reg]));
  endproperty
  a_one_bit: assert property (p_one_bit)
    else $error("bit operation changed more than one bit");

  property p_bit_old;
    @(posedge clock_i) disable iff (!rst_n_i)
    state_reg == QBP_ST_READ
      |=> bit_old_reg == $past(latch_reg[bit_idx_reg][bit_sel_reg]);
  endproperty
  a_bit_old: assert property (p_bit_old)
    else $error("bit operation did not read the latch");

  property p_clr_write;
    @(posedge clock_i) disable iff (!rst_n_i)
    (state_reg == QBP_ST_WRITE && bit_op_reg == QBP_OP_CLRBIT)
      |=> !latch_reg[bit_idx_reg][bit_sel_reg];
  endproperty
  a_clr_write: assert property (p_clr_write)
    else $error("clear bit did not land in latch");

  c_rmw_read: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    sfr_rd_i && hit && sfr_op_i == QBP_OP_XOR);
  c_bit_op: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    bit_done_reg);
  c_pin_diff: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    sfr_rd_i && hit && sfr_op_i == QBP_OP_PLAIN
      && pin_i[idx] != latch_reg[idx]);

endmodule : qbp_port_latch

// ===== tb/qbp_pin_model.sv
`timescale 1ns/100ps
module qbp_pin_model (
  input  wire logic [3:0][7:0] pulldown_i,
  input  wire logic [3:0][7:0] kick_i,
  input  wire logic [3:0][7:0] keeper_i,
  input  wire logic [3:0][7:0] very_weak_i,
  input  wire logic [3:0][7:0] ext_low_i,
  output logic      [3:0][7:0] pin_o
);
  // an external low sinks all pull-up current; no pull leaves a low
  assign pin_o = ~pulldown_i & ~ext_low_i
               & (kick_i | keeper_i | very_weak_i);
endmodule : qbp_pin_model

// ===== tb/qbp_port_latch_tb.sv
`timescale 1ns/100ps
module qbp_port_latch_tb;
  import qbp_pkg::*;
  logic            clock_i;
  logic            rst_n_i;
  logic            rd;
  logic            wr;
  logic            bit_req;
  logic            carry;
  logic [7:0]      addr;
  logic [7:0]      wdata;
  logic [7:0]      rdata;
  logic [2:0]      sel;
  qbp_op_t         op;
  logic            rvalid;
  logic            done;
  logic            old;
  logic [3:0][7:0] pin;
  logic [3:0][7:0] ext_low;
  logic [3:0][7:0] pd;
  logic [3:0][7:0] kick;
  logic [3:0][7:0] keep;
  logic [3:0][7:0] vw;
  int              errors;
  int              samples_checked;

  qbp_port_latch i_qbp_port_latch (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr),
    .sfr_rd_i(rd), .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_op_i(op),
    .sfr_bit_i(bit_req), .sfr_bit_sel_i(sel), .sfr_carry_i(carry),
    .pin_i(pin), .rd_data_o(rdata), .rd_valid_o(rvalid),
    .bit_done_o(done), .bit_old_o(old), .pulldown_o(pd),
    .strong_kick_pullup_o(kick), .weak_keeper_pullup_o(keep),
    .very_weak_pullup_o(vw));

  qbp_pin_model i_qbp_pin_model (
    .pulldown_i(pd), .kick_i(kick), .keeper_i(keep),
    .very_weak_i(vw), .ext_low_i(ext_low), .pin_o(pin));

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // inputs always move 1 ns after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick

  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask : wr_byte

  task automatic rd_byte(input logic [7:0] a, input qbp_op_t o,
                         output logic [7:0] d);
    addr = a;
    op = o;
    rd = 1'b1;
    tick(1);
    // answer stands one cycle only, so take it at this edge
    chk({7'h00, rvalid}, 8'h01, "read valid");
    d = rdata;
    rd = 1'b0;
    tick(1);
  endtask : rd_byte

  task automatic bit_op(input qbp_op_t o, input logic [2:0] s,
                        input logic c);
    addr = 8'h90;
    op = o;
    sel = s;
    carry = c;
    bit_req = 1'b1;
    tick(1);
    bit_req = 1'b0;
    tick(2);
    chk({7'h00, done}, 8'h01, "bit done");
  endtask : bit_op

  task automatic t_reset();
    logic [7:0] d;
    logic [7:0] a [4] = '{8'h90, 8'ha0, 8'hb0, 8'hc0};
    foreach (a[k]) begin
      rd_byte(a[k], QBP_OP_AND, d);
      chk(d, 8'hff, "latch after reset");
    end
    rd_byte(8'h80, QBP_OP_PLAIN, d);
    chk(d, 8'hff, "unmapped read");
    $display("test reset values done");
  endtask : t_reset

  task automatic t_read_class();
    logic [7:0] d;
    ext_low[0] = 8'h21; // latch holds one, pin used as input
    tick(1);
    rd_byte(8'h90, QBP_OP_PLAIN, d);
    chk(d, 8'hde, "plain read sees pins");
    for (int k = 1; k < 12; k++) begin
      rd_byte(8'h90, qbp_op_t'(k), d);
      chk(d, 8'hff, "modify read sees latch");
    end
    $display("test read class done");
  endtask : t_read_class

  // pins 0 and 5 held low outside: a pin-based bit op would lose them
  task automatic t_bit_ops();
    logic [7:0] d;
    qbp_op_t    o [6] = '{QBP_OP_CLRBIT, QBP_OP_CPL, QBP_OP_MOVBIT,
                          QBP_OP_JBC, QBP_OP_MOVBIT, QBP_OP_SETBIT};
    logic [2:0] s [6] = '{3'h5, 3'h1, 3'h5, 3'h6, 3'h7, 3'h6};
    logic [7:0] e [6] = '{8'hdf, 8'hdd, 8'hfd, 8'hbd, 8'h3d, 8'h7d};
    logic       b [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic       c [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    foreach (o[k]) begin
      bit_op(o[k], s[k], c[k]);
      chk({7'h00, old}, {7'h00, b[k]}, "old bit");
      rd_byte(8'h90, QBP_OP_AND, d);
      chk(d, e[k], "bit op byte");
    end
    ext_low[0] = 8'h00;
    $display("test bit ops done");
  endtask : t_bit_ops

  // port two has no strong kick, port three does
  task automatic t_pullups();
    // an idle edge between writes keeps the strobe from re-rising at once
    wr_byte(8'ha0, 8'h00);
    tick(1);
    wr_byte(8'hb0, 8'h00);
    tick(1);
    chk(pd[2], 8'h00, "pull-down not yet on");
    tick(1);
    chk(pd[2], 8'hff, "pull-down on");
    chk(vw[2] | keep[2], 8'h00, "pull-ups off");
    wr_byte(8'ha0, 8'hff);
    tick(1);
    wr_byte(8'hb0, 8'hff);
    tick(2);
    chk(pd[2], 8'h00, "pull-down released");
    chk(vw[2], 8'hff, "very weak on");
    chk(kick[2], 8'hff, "kick first period");
    tick(1);
    chk(kick[2], 8'hff, "kick second period");
    chk(keep[2], 8'hff, "keeper follows pin");
    chk(kick[1], 8'h00, "no kick on port two");
    tick(1);
    chk(kick[2], 8'h00, "kick ends");
    $display("test pull-ups done");
  endtask : t_pullups

  task automatic t_mid_reset();
    logic [7:0] d;
    wr_byte(8'hc0, 8'h00);
    tick(3);
    rst_n_i = 1'b0;
    for (int k = 0; k < 3; k++) begin
      tick(1);
      chk({7'h00, |kick}, 8'h00, "no kick in reset");
    end
    rst_n_i = 1'b1;
    tick(1);
    chk({7'h00, |kick}, 8'h00, "no kick at release");
    rd_byte(8'hc0, QBP_OP_AND, d);
    chk(d, 8'hff, "latch after second reset");
    $display("test mid-run reset done");
  endtask : t_mid_reset

  task automatic stop_test();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // whole run is about ninety cycles
  initial begin
    repeat (3000) @(posedge clock_i);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    rst_n_i = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    bit_req = 1'b0;
    carry = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    sel = 3'h0;
    op = QBP_OP_PLAIN;
    ext_low = '0;
    tick(4);
    rst_n_i = 1'b1;
    t_reset();
    t_read_class();
    t_bit_ops();
    t_pullups();
    t_mid_reset();
    stop_test();
  end
endmodule : qbp_port_latch_tb
